//--- hdl/hrt_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module hrt_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input  wire logic                       clk_i,
   input  wire logic                       sys_rst_i,
   // Fill side.
   input  wire logic                       in_valid_i,
   output logic                            in_ready_o,
   input  wire logic [WIDTH-1:0]           in_data_i,
   // Drain side.
   output logic                            out_valid_o,
   input  wire logic                       out_ready_i,
   output logic [WIDTH-1:0]                out_data_o,
   // Fill level.
   output logic [$clog2(DEPTH+1)-1:0]      level_o
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [CW-1:0]    cnt_q, cnt_d;
   logic             push, pop;

   // Handshakes: full and empty come straight from the count.
   assign in_ready_o  = (cnt_q != CW'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem_q[rd_q];
   assign level_o     = cnt_q;
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // Next pointers, count and storage.
   always_comb
   begin
      mem_d = mem_q;
      wr_d  = wr_q;
      rd_d  = rd_q;
      cnt_d = cnt_q;
      if (push)
      begin
         mem_d[wr_q] = in_data_i;
         wr_d        = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
         rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      if (push && !pop)
         cnt_d = cnt_q + 1'b1;
      else if (pop && !push)
         cnt_d = cnt_q - 1'b1;
   end

   // Registers.
   always_ff @(posedge clk_i)
   begin
      mem_q <= mem_d;
      if (sys_rst_i)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

endmodule
`default_nettype wire

//--- hdl/hrt_pkg.sv
`default_nettype none
package hrt_pkg;

   // Register offsets on the serial control bus.
   localparam logic [7:0] OFS_DETECT_CFG       = 8'h18;
   localparam logic [7:0] OFS_TRACK_CFG        = 8'h1D;
   localparam logic [7:0] OFS_TRACK_MARGIN     = 8'h22;
   localparam logic [7:0] OFS_DETECT_PER_HI    = 8'h25;
   localparam logic [7:0] OFS_DETECT_PER_LO    = 8'h26;
   localparam logic [7:0] OFS_CONT_PER_HI      = 8'h27;
   localparam logic [7:0] OFS_CONT_PER_LO      = 8'h28;
   localparam logic [7:0] OFS_WAVE_START_HI    = 8'h2D;
   localparam logic [7:0] OFS_WAVE_START_LO    = 8'h2E;
   localparam logic [7:0] OFS_FIFO_THRESH_HI   = 8'h2F;
   localparam logic [7:0] OFS_LOW_WATER_LO     = 8'h30;
   localparam logic [7:0] OFS_HIGH_WATER_LO    = 8'h31;
   localparam logic [7:0] OFS_STREAM_ENTRY     = 8'h32;
   localparam logic [7:0] OFS_TRIGGER_INPUT_1_RISE       = 8'h33;
   localparam logic [7:0] OFS_TRIG2_RISE       = 8'h34;

   // Reset values.
   localparam logic [7:0] RST_DETECT_CFG       = 8'hE1;
   localparam logic [7:0] RST_TRACK_CFG        = 8'hFF;
   localparam logic [7:0] RST_TRACK_MARGIN     = 8'h0F;
   localparam logic [7:0] RST_PERIOD_BYTE      = 8'h00;
   localparam logic [7:0] RST_WAVE_START_HI    = 8'h38;
   localparam logic [7:0] RST_WAVE_START_LO    = 8'h00;
   localparam logic [7:0] RST_FIFO_THRESH_HI   = 8'h26;
   localparam logic [7:0] RST_LOW_WATER_LO     = 8'h00;
   localparam logic [7:0] RST_HIGH_WATER_LO    = 8'h00;
   localparam logic [7:0] RST_STREAM_ENTRY     = 8'h00;
   localparam logic [7:0] RST_TRIG_RISE        = 8'h01;
   localparam logic [7:0] RD_UNMAPPED          = 8'h00;

   // Field positions.
   localparam int DETECT_EN_BIT  = 3;
   localparam int TRACK_EN_BIT   = 7;
   localparam int RISE_EN_BIT    = 7;
   localparam int SEQ_MSB        = 6;
   localparam int AE_HI_LSB      = 4;
   localparam int AF_HI_LSB      = 0;
   localparam int HI_FIELD_W     = 4;

   // Stream buffer geometry.
   localparam int SAMPLE_W       = 8;
   localparam int STREAM_DEPTH   = 8;

   // One finished period measurement from a resonance engine.
   typedef struct packed {
      logic        done;
      logic [15:0] period;
   } hrt_meas_t;

   // One trigger pin event for the playback engine.
   typedef struct packed {
      logic       fire;
      logic       pin2;
      logic [6:0] seq;
   } hrt_trig_t;

   // Configuration handed to the engines.
   typedef struct packed {
      logic        detect_en;
      logic        track_en;
      logic [7:0]  track_margin;
      logic [11:0] wave_start;
      logic [11:0] low_water;
      logic [11:0] high_water;
   } hrt_cfg_t;

endpackage
`default_nettype wire

//--- hdl/hrt_regs.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
//
// Contract
// (R1) Tracking margin 8 bits, resets to 15.
// (R2) Detection period readback, two RO bytes.
// (R3) Continuous period readback, two RO bytes.
// (R4) Wave start address high*256+low, high 0x08.
// (R5) Low-water threshold high*256+low, high 0x02.
// (R6) High-water threshold high*256+low, high 0x06.
// (R7) Stream entry writes push into FIFO.
// (R8) Trigger 1 rise enable and sequence.
// (R9) Trigger 2 rise enable and sequence.
// (R10) Detection period updates only while detection enabled.
// (R11) Tracking period updates only while tracking enabled.
// (R12) Period readbacks hold until next measurement.
module hrt_regs
   import hrt_pkg::*;
#(
   parameter int DEPTH = STREAM_DEPTH
) (
   // Clock and reset.
   input  wire logic                 clk_i,
   input  wire logic                 sys_rst_i,
   // Register access from the serial bus front end.
   input  wire logic                 reg_wr_i,
   input  wire logic                 reg_rd_i,
   input  wire logic [7:0]           reg_addr_i,
   input  wire logic [7:0]           reg_wdata_i,
   output logic [7:0]                reg_rdata_o,
   output logic                      stream_ready_o,
   // Measurements from the resonance engines.
   input  wire hrt_meas_t            detect_meas_i,
   input  wire hrt_meas_t            track_meas_i,
   // Trigger pins.
   input  wire logic                 trigger_input_1_i,
   input  wire logic                 trigger_input_2_i,
   // Playback engine side.
   output hrt_cfg_t                  cfg_o,
   output hrt_trig_t                 trig_o,
   output logic                      sample_valid_o,
   input  wire logic                 sample_ready_i,
   output logic [SAMPLE_W-1:0]       sample_data_o,
   output logic                      low_water_o,
   output logic                      high_water_o
);

   localparam int LW = $clog2(DEPTH+1);

   // Decodes a write strobe for one register offset.
   function automatic logic wr_hit(input logic we, input logic [7:0] a,
                                   input logic [7:0] ofs);
      return we && (a == ofs);
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // Register state.

   logic [7:0]  detect_cfg_q,   detect_cfg_d;
   logic [7:0]  track_cfg_q,    track_cfg_d;
   logic [7:0]  margin_q,       margin_d;
   logic [15:0] det_per_q,      det_per_d;
   logic [15:0] cont_per_q,     cont_per_d;
   logic [7:0]  start_hi_q,     start_hi_d;
   logic [7:0]  start_lo_q,     start_lo_d;
   logic [7:0]  thresh_hi_q,    thresh_hi_d;
   logic [7:0]  low_water_lo_q, low_water_lo_d;
   logic [7:0]  high_water_lo_q, high_water_lo_d;
   logic [7:0]  entry_q,        entry_d;
   logic [7:0]  trigger_input_1_q,        trigger_input_1_d;
   logic [7:0]  trig2_q,        trig2_d;
   logic [7:0]  rdata_q,        rdata_d;

   logic             entry_push;
   logic [LW-1:0]    level;

   // Next values of the software registers and readbacks.
   always_comb
   begin
      detect_cfg_d    = detect_cfg_q;
      track_cfg_d     = track_cfg_q;
      margin_d        = margin_q;
      det_per_d       = det_per_q;
      cont_per_d      = cont_per_q;
      start_hi_d      = start_hi_q;
      start_lo_d      = start_lo_q;
      thresh_hi_d     = thresh_hi_q;
      low_water_lo_d  = low_water_lo_q;
      high_water_lo_d = high_water_lo_q;
      entry_d         = entry_q;
      trigger_input_1_d         = trigger_input_1_q;
      trig2_d         = trig2_q;
      if (wr_hit(reg_wr_i, reg_addr_i, OFS_DETECT_CFG))
         detect_cfg_d = reg_wdata_i;
      if (wr_hit(reg_wr_i, reg_addr_i, OFS_TRACK_CFG))
         track_cfg_d = reg_wdata_i;
      if (wr_hit(reg_wr_i, reg_addr_i, OFS_TRACK_MARGIN))
         margin_d = reg_wdata_i;                                  // (R1)
      if (wr_hit(reg_wr_i, reg_addr_i, OFS_WAVE_START_HI))
         start_hi_d = reg_wdata_i;                                // (R4)
      if (wr_hit(reg_wr_i, reg_addr_i, OFS_WAVE_START_LO))
         start_lo_d = reg_wdata_i;                                // (R4)
      if (wr_hit(reg_wr_i, reg_addr_i, OFS_FIFO_THRESH_HI))
         thresh_hi_d = reg_wdata_i;                               // (R5)
      if (wr_hit(reg_wr_i, reg_addr_i, OFS_LOW_WATER_LO))
         low_water_lo_d = reg_wdata_i;                            // (R5)
      if (wr_hit(reg_wr_i, reg_addr_i, OFS_HIGH_WATER_LO))
         high_water_lo_d = reg_wdata_i;                           // (R6)
      if (wr_hit(reg_wr_i, reg_addr_i, OFS_STREAM_ENTRY))
         entry_d = reg_wdata_i;
      if (wr_hit(reg_wr_i, reg_addr_i, OFS_TRIGGER_INPUT_1_RISE))
         trigger_input_1_d = reg_wdata_i;                                   // (R8)
      if (wr_hit(reg_wr_i, reg_addr_i, OFS_TRIG2_RISE))
         trig2_d = reg_wdata_i;                                   // (R9)
      // Readbacks change only when a finished measurement arrives.
      if (detect_meas_i.done && detect_cfg_q[DETECT_EN_BIT])     // (R10)
         det_per_d = detect_meas_i.period;                        // (R2) (R12)
      if (track_meas_i.done && track_cfg_q[TRACK_EN_BIT])        // (R11)
         cont_per_d = track_meas_i.period;                        // (R3) (R12)
   end

   // Read data mux; writes to read-only bytes are ignored.
   always_comb
   begin
      rdata_d = rdata_q;
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            OFS_DETECT_CFG:     rdata_d = detect_cfg_q;
            OFS_TRACK_CFG:      rdata_d = track_cfg_q;
            OFS_TRACK_MARGIN:   rdata_d = margin_q;
            OFS_DETECT_PER_HI:  rdata_d = det_per_q[15:8];        // (R2)
            OFS_DETECT_PER_LO:  rdata_d = det_per_q[7:0];         // (R2)
            OFS_CONT_PER_HI:    rdata_d = cont_per_q[15:8];       // (R3)
            OFS_CONT_PER_LO:    rdata_d = cont_per_q[7:0];        // (R3)
            OFS_WAVE_START_HI:  rdata_d = start_hi_q;
            OFS_WAVE_START_LO:  rdata_d = start_lo_q;
            OFS_FIFO_THRESH_HI: rdata_d = thresh_hi_q;
            OFS_LOW_WATER_LO:   rdata_d = low_water_lo_q;
            OFS_HIGH_WATER_LO:  rdata_d = high_water_lo_q;
            OFS_STREAM_ENTRY:   rdata_d = entry_q;
            OFS_TRIGGER_INPUT_1_RISE:     rdata_d = trigger_input_1_q;
            OFS_TRIG2_RISE:     rdata_d = trig2_q;
            default:            rdata_d = RD_UNMAPPED;
         endcase
      end
   end

   // Register storage.
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         detect_cfg_q    <= RST_DETECT_CFG;
         track_cfg_q     <= RST_TRACK_CFG;
         margin_q        <= RST_TRACK_MARGIN;                     // (R1)
         det_per_q       <= {RST_PERIOD_BYTE, RST_PERIOD_BYTE};   // (R2)
         cont_per_q      <= {RST_PERIOD_BYTE, RST_PERIOD_BYTE};   // (R3)
         start_hi_q      <= RST_WAVE_START_HI;                    // (R4)
         start_lo_q      <= RST_WAVE_START_LO;
         thresh_hi_q     <= RST_FIFO_THRESH_HI;                   // (R5) (R6)
         low_water_lo_q  <= RST_LOW_WATER_LO;
         high_water_lo_q <= RST_HIGH_WATER_LO;
         entry_q         <= RST_STREAM_ENTRY;
         trigger_input_1_q         <= RST_TRIG_RISE;                        // (R8)
         trig2_q         <= RST_TRIG_RISE;                        // (R9)
         rdata_q         <= RD_UNMAPPED;
      end
      else
      begin
         detect_cfg_q    <= detect_cfg_d;
         track_cfg_q     <= track_cfg_d;
         margin_q        <= margin_d;
         det_per_q       <= det_per_d;
         cont_per_q      <= cont_per_d;
         start_hi_q      <= start_hi_d;
         start_lo_q      <= start_lo_d;
         thresh_hi_q     <= thresh_hi_d;
         low_water_lo_q  <= low_water_lo_d;
         high_water_lo_q <= high_water_lo_d;
         entry_q         <= entry_d;
         trigger_input_1_q         <= trigger_input_1_d;
         trig2_q         <= trig2_d;
         rdata_q         <= rdata_d;
      end
   end

   assign reg_rdata_o = rdata_q;

   // Configuration fields handed to the engines.
   always_comb
   begin
      cfg_o.detect_en    = detect_cfg_q[DETECT_EN_BIT];          // (R10)
      cfg_o.track_en     = track_cfg_q[TRACK_EN_BIT];            // (R11)
      cfg_o.track_margin = margin_q;                             // (R1)
      cfg_o.wave_start   = {start_hi_q[HI_FIELD_W-1:0], start_lo_q};  // (R4)
      cfg_o.low_water    = {thresh_hi_q[AE_HI_LSB +: HI_FIELD_W],
                            low_water_lo_q};                     // (R5)
      cfg_o.high_water   = {thresh_hi_q[AF_HI_LSB +: HI_FIELD_W],
                            high_water_lo_q};                    // (R6)
   end

   //////////////////////////////////////////////////////////////////////////
   // Stream path: each entry write made while the FIFO has room becomes one FIFO push; writes to a full FIFO are dropped.

   assign entry_push = wr_hit(reg_wr_i, reg_addr_i, OFS_STREAM_ENTRY); // (R7)

   hrt_fifo #(
      .WIDTH (SAMPLE_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .in_valid_i  (entry_push),                                 // (R7)
      .in_ready_o  (stream_ready_o),
      .in_data_i   (reg_wdata_i),
      .out_valid_o (sample_valid_o),
      .out_ready_i (sample_ready_i),
      .out_data_o  (sample_data_o),
      .level_o     (level)
   );

   // Water marks compare the fill level against the thresholds.
   always_comb
   begin
      low_water_o  = (12'(level) <= cfg_o.low_water);            // (R5)
      high_water_o = (12'(level) >= cfg_o.high_water);           // (R6)
   end

   //////////////////////////////////////////////////////////////////////////
   // Trigger pins: two-flop synchronisers, then rising-edge detection.

   logic [1:0] pin_meta_q, pin_meta_d;
   logic [1:0] pin_sync_q, pin_sync_d;
   logic [1:0] pin_prev_q, pin_prev_d;
   hrt_trig_t  trig_q,     trig_d;
   logic [1:0] rise;

   // Next values of the synchronisers and the trigger event.
   always_comb
   begin
      pin_meta_d = {trigger_input_2_i, trigger_input_1_i};
      pin_sync_d = pin_meta_q;
      pin_prev_d = pin_sync_q;
      rise       = pin_sync_q & ~pin_prev_q;
      trig_d     = '0;
      // Pin 1 wins when both pins rise in the same cycle with both rise enables set.
      if (rise[0] && trigger_input_1_q[RISE_EN_BIT])                       // (R8)
      begin
         trig_d.fire = 1'b1;
         trig_d.seq  = trigger_input_1_q[SEQ_MSB:0];                       // (R8)
      end
      else if (rise[1] && trig2_q[RISE_EN_BIT])                  // (R9)
      begin
         trig_d.fire = 1'b1;
         trig_d.pin2 = 1'b1;
         trig_d.seq  = trig2_q[SEQ_MSB:0];                       // (R9)
      end
   end

   // Synchroniser and event registers; edge history starts low.
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
         pin_prev_q <= '0;
         trig_q     <= '0;
      end
      else
      begin
         pin_meta_q <= pin_meta_d;
         pin_sync_q <= pin_sync_d;
         pin_prev_q <= pin_prev_d;
         trig_q     <= trig_d;
      end
   end

   assign trig_o = trig_q;

endmodule
`default_nettype wire

//--- sim/hrt_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module hrt_regs_chk
   import hrt_pkg::*;
(
   // Clock and reset.
   input wire logic       clk_i,
   input wire logic       sys_rst_i,
   // Register port.
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   // Engines, pins and playback side.
   input wire hrt_meas_t  detect_meas_i,
   input wire hrt_meas_t  track_meas_i,
   input wire logic       trigger_input_1_i,
   input wire logic       trigger_input_2_i,
   input wire hrt_cfg_t   cfg_o,
   input wire hrt_trig_t  trig_o,
   input wire logic       stream_ready_o,
   input wire logic       sample_valid_o,
   input wire logic       sample_ready_i,
   input wire logic [7:0] sample_data_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   //////////////////////////////////////////////////////////////////////////////
   // Register side relations.
   a_cfg_reset: assert property ($fell(sys_rst_i) |->
      cfg_o.track_margin == 8'h0F && cfg_o.wave_start == 12'h800
      && cfg_o.low_water == 12'h200 && cfg_o.high_water == 12'h600)
      else $error("config not at reset values");
   a_margin_write: assert property (reg_wr_i && reg_addr_i == OFS_TRACK_MARGIN |=>
      cfg_o.track_margin == $past(reg_wdata_i)) else $error("margin write lost");
   a_wave_low: assert property (reg_wr_i && reg_addr_i == OFS_WAVE_START_LO |=>
      cfg_o.wave_start[7:0] == $past(reg_wdata_i)) else $error("wave start low lost");
   a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   a_detect_read: assert property (detect_meas_i.done && cfg_o.detect_en ##1
      reg_rd_i && reg_addr_i == OFS_DETECT_PER_HI |=>
      reg_rdata_o == $past(detect_meas_i.period[15:8], 2)) else $error("detect high wrong");
   a_track_read: assert property (track_meas_i.done && cfg_o.track_en ##1
      reg_rd_i && reg_addr_i == OFS_CONT_PER_LO |=>
      reg_rdata_o == $past(track_meas_i.period[7:0], 2)) else $error("track low wrong");
   a_period_keep: assert property ((reg_rd_i && reg_addr_i == OFS_DETECT_PER_LO
      && !(detect_meas_i.done && cfg_o.detect_en)) ##1 !(detect_meas_i.done && cfg_o.detect_en)
      ##1 (reg_rd_i && reg_addr_i == OFS_DETECT_PER_LO) |=>
      reg_rdata_o == $past(reg_rdata_o, 2)) else $error("detect period changed");
   //////////////////////////////////////////////////////////////////////////////
   // Trigger and stream relations.
   a_fire_single: assert property (trig_o.fire |=>
      !(trig_o.fire && trig_o.pin2 == $past(trig_o.pin2)))
      else $error("same pin fired on two cycles in a row");
   a_pin1_cause: assert property (trig_o.fire && !trig_o.pin2 |->
      $past(trigger_input_1_i, 3) && !$past(trigger_input_1_i, 4)) else $error("pin 1 fire");
   a_pin2_cause: assert property (trig_o.fire && trig_o.pin2 |->
      $past(trigger_input_2_i, 3) && !$past(trigger_input_2_i, 4)) else $error("pin 2 fire");
   a_push_head: assert property (reg_wr_i && reg_addr_i == OFS_STREAM_ENTRY
      && !sample_valid_o |=> sample_valid_o && sample_data_o == $past(reg_wdata_i))
      else $error("entry byte not at head");
   a_full_stays: assert property (!stream_ready_o && !sample_ready_i |=> !stream_ready_o)
      else $error("full buffer lost a byte");
endmodule
`default_nettype wire

//--- sim/hrt_sink.sv
`timescale 1ns/1ps
`default_nettype none
module hrt_sink
   import hrt_pkg::*;
(
   // Clock and reset.
   input  wire logic                clk_i,
   input  wire logic                sys_rst_i,
   // Stall request from the bench.
   input  wire logic                stall_i,
   // Drain side of the stream buffer.
   input  wire logic                sample_valid_i,
   output logic                     sample_ready_o,
   input  wire logic [SAMPLE_W-1:0] sample_data_i
);
   logic [SAMPLE_W-1:0] got [0:15];
   int                  cnt;
   // Accepts whenever the bench does not stall, like a playback engine.
   assign sample_ready_o = !stall_i;
   // Records every accepted byte in arrival order.
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         cnt <= 0;
      else if (sample_valid_i && sample_ready_o)
      begin
         got[cnt[3:0]] <= sample_data_i;
         cnt <= cnt + 1;
      end
   end
endmodule
`default_nettype wire

//--- sim/test_haptic_rtp_trigger_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_haptic_rtp_trigger_regs
   import hrt_pkg::*;
();
   logic       clk_i = 1'b0;
   logic       sys_rst_i = 1'b1;
   logic       reg_wr, reg_rd, pin1, pin2, stall, s_rdy, s_vld, st_rdy, lo_w, hi_w;
   logic [7:0] addr, wdata, rdata, s_data;
   hrt_meas_t  det_m, trk_m;
   hrt_cfg_t   cfg;
   hrt_trig_t  trig, t_last;
   int         err_total, cmp_count, n_fire, i;
   logic [7:0] ofs [13] = '{8'h18, 8'h1D, 8'h22, 8'h25, 8'h26, 8'h27, 8'h28, 8'h2D,
                            8'h2E, 8'h2F, 8'h30, 8'h33, 8'h40};
   logic [7:0] rst [13] = '{8'hE1, 8'hFF, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h38,
                            8'h00, 8'h26, 8'h00, 8'h01, 8'h00};
   // Clock at 250 MHz.
   always #2 clk_i = ~clk_i;
   hrt_regs #(.DEPTH(8)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .stream_ready_o(st_rdy), .detect_meas_i(det_m), .track_meas_i(trk_m),
      .trigger_input_1_i(pin1), .trigger_input_2_i(pin2), .cfg_o(cfg), .trig_o(trig),
      .sample_valid_o(s_vld), .sample_ready_i(s_rdy), .sample_data_o(s_data),
      .low_water_o(lo_w), .high_water_o(hi_w));
   hrt_sink sink (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .stall_i(stall),
      .sample_valid_i(s_vld), .sample_ready_o(s_rdy), .sample_data_i(s_data));
   // Counts trigger events and keeps the latest one.
   always @(posedge clk_i)
   begin
      if (trig.fire === 1'b1)
      begin
         n_fire <= n_fire + 1;
         t_last <= trig;
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // Shared tasks.
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // One write strobe, then an idle cycle so strobes never merge.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      reg_wr = 1'b1;
      @(posedge clk_i);
      #1;
      reg_wr = 1'b0;
      @(posedge clk_i);
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      addr = a;
      reg_rd = 1'b1;
      @(posedge clk_i);
      #1;
      reg_rd = 1'b0;
      @(posedge clk_i);
      #1;
      chk($sformatf("register %h", a), {8'h00, rdata}, {8'h00, e});
   endtask
   task automatic meas(input bit trk, input logic [15:0] p);
      if (trk)
         trk_m = {1'b1, p};
      else
         det_m = {1'b1, p};
      @(posedge clk_i);
      #1;
      det_m.done = 1'b0;
      trk_m.done = 1'b0;
   endtask
   // Raises the selected pins for three cycles and counts fires in a fixed window.
   task automatic pulse(input logic [1:0] pins, input logic [15:0] exp_n);
      int n0;
      n0 = n_fire;
      {pin2, pin1} = pins;
      repeat (3) @(posedge clk_i);
      #1;
      pin1 = 1'b0;
      pin2 = 1'b0;
      repeat (10) @(posedge clk_i);
      #1;
      chk("fire count", 16'(n_fire - n0), exp_n);
   endtask
   //////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      {reg_wr, reg_rd, pin1, pin2, stall} = 5'h00;
      addr = 8'h00;
      wdata = 8'h00;
      det_m = '0;
      trk_m = '0;
      err_total = 0;
      cmp_count = 0;
      n_fire = 0;
      repeat (10) @(posedge clk_i);
      #1;
      sys_rst_i = 1'b0;
      foreach (ofs[k]) rd_chk(ofs[k], rst[k]);
      rd_chk(8'h34, 8'h01);
      chk("cfg enables", {14'h0, cfg.detect_en, cfg.track_en}, 16'h0001);
      $display("test reset finished");
      wr_reg(8'h22, 8'hA5);
      rd_chk(8'h22, 8'hA5);
      wr_reg(8'h2D, 8'h3B);
      wr_reg(8'h2E, 8'h7C);
      chk("wave start", {4'h0, cfg.wave_start}, 16'h0B7C);
      wr_reg(8'h30, 8'h02);
      wr_reg(8'h31, 8'h06);
      wr_reg(8'h2F, 8'h5A);
      chk("low water", {4'h0, cfg.low_water}, 16'h0502);
      chk("high water", {4'h0, cfg.high_water}, 16'h0A06);
      wr_reg(8'h2F, 8'h00);
      wr_reg(8'h25, 8'hFF);
      rd_chk(8'h25, 8'h00);
      $display("test config finished");
      meas(1'b0, 16'h1234);
      rd_chk(8'h25, 8'h00);
      wr_reg(8'h18, 8'hE9);
      meas(1'b0, 16'h1234);
      rd_chk(8'h25, 8'h12);
      rd_chk(8'h26, 8'h34);
      wr_reg(8'h18, 8'hE1);
      meas(1'b0, 16'h5555);
      rd_chk(8'h26, 8'h34);
      rd_chk(8'h26, 8'h34);
      wr_reg(8'h1D, 8'h7F);
      meas(1'b1, 16'hABCD);
      rd_chk(8'h27, 8'h00);
      wr_reg(8'h1D, 8'hFF);
      meas(1'b1, 16'hABCD);
      rd_chk(8'h28, 8'hCD);
      rd_chk(8'h27, 8'hAB);
      $display("test periods finished");
      stall = 1'b1;
      for (i = 1; i <= 9; i++)
      begin
         wr_reg(OFS_STREAM_ENTRY, 8'(8'h10 + i));
         chk("buffer ready", {15'h0, st_rdy}, {15'h0, i < 8});
         chk("low water flag", {15'h0, lo_w}, {15'h0, i <= 2});
         chk("high water flag", {15'h0, hi_w}, {15'h0, i >= 6});
      end
      stall = 1'b0;
      for (i = 0; i < 30 && s_vld !== 1'b0; i++)
      begin
         @(posedge clk_i);
         #1;
      end
      // A buffer that never drains counts as a mismatch; the run goes on to the verdict.
      if (s_vld !== 1'b0)
         err_total++;
      chk("drained count", 16'(sink.cnt), 16'd8);
      for (i = 0; i < 8; i++) chk("drained byte", {8'h00, sink.got[i]}, 16'(8'h11 + i));
      rd_chk(8'h32, 8'h19);
      $display("test stream finished");
      wr_reg(8'h33, 8'h85);
      wr_reg(8'h34, 8'h8A);
      pulse(2'b01, 16'd1);
      chk("pin 1 event", {7'h0, t_last}, 16'h0105);
      pulse(2'b10, 16'd1);
      chk("pin 2 event", {7'h0, t_last}, 16'h018A);
      pulse(2'b11, 16'd1);
      chk("both pins event", {7'h0, t_last}, 16'h0105);
      wr_reg(8'h33, 8'h05);
      pulse(2'b01, 16'd0);
      pulse(2'b11, 16'd1);
      chk("pin 2 alone event", {7'h0, t_last}, 16'h018A);
      $display("test triggers finished");
      close_out();
   end
endmodule
bind hrt_regs hrt_regs_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .detect_meas_i(detect_meas_i), .track_meas_i(track_meas_i),
   .trigger_input_1_i(trigger_input_1_i), .trigger_input_2_i(trigger_input_2_i),
   .cfg_o(cfg_o), .trig_o(trig_o), .stream_ready_o(stream_ready_o),
   .sample_valid_o(sample_valid_o), .sample_ready_i(sample_ready_i),
   .sample_data_o(sample_data_o));
`default_nettype wire
